// >>> ars_conv_model.sv
// Converter model: answers each start after a short or long delay
`timescale 1ns/1ps
`default_nettype none
module ars_conv_model
    import ars_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst,
    input wire ars_conv_req_t conv_req,
    output ars_conv_res_t     conv_res
);
    logic       busy;
    logic [2:0] cnt;
    logic [6:0] n;
    logic [4:0] ch;
    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
            n <= 7'h00;
            conv_res <= '0;
        end else begin
            conv_res.done <= 1'b0;
            // Data toggles outside the done pulse so a stale read shows
            conv_res.data <= ~conv_res.data;
            if (conv_req.start) begin
                busy <= 1'b1;
                cnt <= n[0] ? 3'h6 : 3'h0;
                ch <= conv_req.channel;
            end else if (busy && cnt == 3'h0) begin
                busy <= 1'b0;
                conv_res.done <= 1'b1;
                conv_res.data <= {n, ch};
                n <= n + 7'h01;
            end else if (busy) begin
                cnt <= cnt - 3'h1;
            end
        end
    end
endmodule : ars_conv_model
`default_nettype wire

// >>> ars_params.svh
// Offsets, field positions, response codes and counts for the converter result sequencer
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH

`define ARS_ADDR_W        8
`define ARS_DATA_W        12
`define ARS_CH_W          5
`define ARS_NBUF          16
`define ARS_NPIN          16

`define ARS_OFF_CTRL_ONE  8'h00
`define ARS_OFF_CTRL_TWO  8'h04
`define ARS_OFF_SCAN_LO   8'h08
`define ARS_OFF_SCAN_HI   8'h0C
`define ARS_OFF_PCFG_OWN  8'h10
`define ARS_OFF_PCFG_PEER 8'h14
`define ARS_OFF_IRQ_STAT  8'h18
`define ARS_OFF_IRQ_MASK  8'h1C
`define ARS_OFF_STATUS    8'h20
`define ARS_OFF_BUF_BASE  8'h40
`define ARS_OFF_BUF_LAST  8'h7C

`define ARS_B_DONE        0
`define ARS_B_SAMPLE      1
`define ARS_B_DMA         2
`define ARS_B_SCAN_EN     10
`define ARS_F_CONVERSIONS_PER_IRQ_SEL_LO     2
`define ARS_F_CONVERSIONS_PER_IRQ_SEL_HI     5
`define ARS_F_FCH_LO      16
`define ARS_F_FCH_HI      20

`define ARS_IRQ_SEQ       0
`define ARS_IRQ_OVR       1
`define ARS_NIRQ          2

`define ARS_RESP_OKAY     2'h0
`define ARS_RESP_SLVERR   2'h2

`endif

// >>> ars_pkg.sv
// Types shared by the converter result sequencer and its users
`include "ars_params.svh"

package ars_pkg;

    typedef enum logic [1:0] {
        ARS_IDLE = 2'b01,
        ARS_CONV = 2'b10
    } ars_fsm_t;

    typedef struct packed {
        logic                   start;
        logic [`ARS_CH_W-1:0]   channel;
    } ars_conv_req_t;

    typedef struct packed {
        logic                   done;
        logic [`ARS_DATA_W-1:0] data;
    } ars_conv_res_t;

    typedef struct packed {
        logic                                     done;
        logic                                     sample;
        logic                                     dma_mode;
        logic [3:0]                               conversions_per_irq_sel;
        logic                                     scan_en;
        logic [`ARS_CH_W-1:0]                     fix_ch;
        logic [15:0]                              scan_lo;
        logic [15:0]                              scan_hi;
        logic [`ARS_NPIN-1:0]                     pcfg_own;
        logic [`ARS_NPIN-1:0]                     pcfg_peer;
        logic [`ARS_NIRQ-1:0]                     irq_st;
        logic [`ARS_NIRQ-1:0]                     irq_mask;
        logic [3:0]                               cnt;
        logic [3:0]                               wptr;
        logic [`ARS_CH_W-1:0]                     spos;
        logic [`ARS_CH_W-1:0]                     cur_ch;
        ars_fsm_t                                 fsm;
        logic [`ARS_NBUF-1:0][`ARS_DATA_W-1:0]    rbuf;
        logic                                     unread;
        logic [`ARS_NPIN-1:0]                     sy1;
        logic [`ARS_NPIN-1:0]                     sy2;
        logic [`ARS_NPIN-1:0]                     sy3;
        logic [`ARS_NPIN-1:0]                     din_q;
        logic [`ARS_NPIN-1:0]                     alt_din;
        logic                                     bvalid;
        logic [1:0]                               bresp;
        logic                                     rvalid;
        logic [1:0]                               rresp;
        logic [31:0]                              rdata;
        ars_conv_req_t                            req;
    } ars_state_t;

endpackage : ars_pkg

// >>> ars_seq.sv
// Converter result sequencer: sampling control, scan, result storage, pin gating
// Behaviour
// R1: Interrupt flag raised after the conversion count set by the per-interrupt field.
// R2: With scan enabled, scan list restarts from its first entry at that point.
// R3: Without DMA, result write pointer returns to the first buffer at that point.
// R4: Without DMA, sixteen result buffers are filled in sequential order.
// R5: Buffer index follows conversion order, never the input channel.
// R6: With DMA, one buffer only; each new result overwrites the previous.
// R7: With DMA, the reader fetches each result before the next completes.
// R8: Done clears at conversion start, sets at completion, stays set meanwhile; a software write of 0 to done also clears it.
// R9: Manual-sampling software clears done itself just before setting sample start.
// R10: A shared pin is digital only when both instances configure it as one.
// R11: Any analog setting disables the input buffer; alternate inputs read zero.
// R12: Wrap and interrupt occur after field value plus one conversions.
`include "ars_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ars_seq (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [`ARS_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    output logic [1:0]                    s_axi_bresp,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    input  wire logic [`ARS_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output ars_pkg::ars_conv_req_t        conv_req,
    input  wire ars_pkg::ars_conv_res_t   conv_res,
    input  wire logic [`ARS_NPIN-1:0]     pin_level,
    output logic [`ARS_NPIN-1:0]          pin_digital_en,
    output logic [`ARS_NPIN-1:0]          alt_digital_in,
    output logic                          irq
);
    import ars_pkg::*;

    ars_state_t s_r;
    ars_state_t s_nxt;

    logic wr_go;
    logic rd_go;

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] ars_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : ars_merge

    // First selected channel at or after the start index, else the lowest selected
    function automatic logic [`ARS_CH_W-1:0] ars_next_ch(
        input logic [31:0]          m,
        input logic [`ARS_CH_W-1:0] from
    );
        logic [`ARS_CH_W-1:0] hit;
        logic [`ARS_CH_W-1:0] low;
        logic                 found;
        hit = from;
        low = from;
        found = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (m[i]) begin
                low = i[`ARS_CH_W-1:0];
                if (i[`ARS_CH_W-1:0] >= from) begin
                    hit = i[`ARS_CH_W-1:0];
                    found = 1'b1;
                end
            end
        end
        return found ? hit : low;
    endfunction : ars_next_ch

    // Address falls in the result buffer window
    function automatic logic ars_in_buf(input logic [`ARS_ADDR_W-1:0] a);
        return (a >= `ARS_OFF_BUF_BASE) && (a <= `ARS_OFF_BUF_LAST);
    endfunction : ars_in_buf

    // Pins that both converter instances leave digital
    function automatic logic [`ARS_NPIN-1:0] ars_digital(
        input logic [`ARS_NPIN-1:0] own,
        input logic [`ARS_NPIN-1:0] peer
    );
        return own & peer;
    endfunction : ars_digital

    // Advance a sequence counter, or restart it at the end of a sequence
    function automatic logic [3:0] ars_step(
        input logic [3:0] v,
        input logic       last
    );
        return last ? 4'h0 : v + 4'h1;
    endfunction : ars_step

    // Register image as software sees it
    function automatic logic [31:0] ars_reg_word(
        input ars_state_t           st,
        input logic [`ARS_ADDR_W-1:0] a
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            `ARS_OFF_CTRL_ONE: begin
                w[`ARS_B_DONE]   = st.done;
                w[`ARS_B_SAMPLE] = st.sample;
                w[`ARS_B_DMA]    = st.dma_mode;
            end
            `ARS_OFF_CTRL_TWO: begin
                w[`ARS_F_CONVERSIONS_PER_IRQ_SEL_HI:`ARS_F_CONVERSIONS_PER_IRQ_SEL_LO] = st.conversions_per_irq_sel;
                w[`ARS_B_SCAN_EN]                = st.scan_en;
                w[`ARS_F_FCH_HI:`ARS_F_FCH_LO]   = st.fix_ch;
            end
            `ARS_OFF_SCAN_LO:   w[15:0] = st.scan_lo;
            `ARS_OFF_SCAN_HI:   w[15:0] = st.scan_hi;
            `ARS_OFF_PCFG_OWN:  w[`ARS_NPIN-1:0] = st.pcfg_own;
            `ARS_OFF_PCFG_PEER: w[`ARS_NPIN-1:0] = st.pcfg_peer;
            `ARS_OFF_IRQ_STAT:  w[`ARS_NIRQ-1:0] = st.irq_st;
            `ARS_OFF_IRQ_MASK:  w[`ARS_NIRQ-1:0] = st.irq_mask;
            `ARS_OFF_STATUS: begin
                w[3:0]   = st.wptr;
                w[11:8]  = st.cnt;
                w[20:16] = st.cur_ch;
                w[24]    = st.unread;
                w[25]    = (st.fsm == ARS_CONV);
            end
            default: begin
                if (ars_in_buf(a) && a[1:0] == 2'h0) begin
                    w[`ARS_DATA_W-1:0] = st.rbuf[a[5:2]];
                end
            end
        endcase
        return w;
    endfunction : ars_reg_word

    function automatic logic ars_mapped(input logic [`ARS_ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= `ARS_OFF_STATUS || ars_in_buf(a));
    endfunction : ars_mapped

    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_r.bvalid;
    assign rd_go         = s_axi_arvalid & ~s_r.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    always_comb begin
        logic [31:0]          w;
        logic [`ARS_CH_W-1:0] ch;
        logic                 wrap;
        logic                 done_set;
        logic                 ovr_set;
        logic                 seq_set;
        logic [`ARS_NIRQ-1:0] clr;
        w        = 32'h0000_0000;
        ch       = '0;
        wrap     = 1'b0;
        done_set = 1'b0;
        ovr_set  = 1'b0;
        seq_set  = 1'b0;
        clr      = '0;
        s_nxt    = s_r;
        s_nxt.req.start = 1'b0;

        // Pin input synchroniser; a change is accepted once stages two and three agree
        s_nxt.sy1 = pin_level;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;
        for (int i = 0; i < `ARS_NPIN; i++) begin
            if (s_r.sy2[i] == s_r.sy3[i]) begin
                s_nxt.din_q[i] = s_r.sy3[i];
            end
        end
        s_nxt.alt_din = s_r.din_q & ars_digital(s_r.pcfg_own, s_r.pcfg_peer); // R11

        // Register writes
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = ars_mapped(s_axi_awaddr) ? `ARS_RESP_OKAY : `ARS_RESP_SLVERR;
            w = ars_merge(ars_reg_word(s_r, s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
            unique case (s_axi_awaddr)
                `ARS_OFF_CTRL_ONE: begin
                    s_nxt.done     = w[`ARS_B_DONE] & s_r.done; // R9
                    s_nxt.sample   = w[`ARS_B_SAMPLE];
                    s_nxt.dma_mode = w[`ARS_B_DMA];
                end
                `ARS_OFF_CTRL_TWO: begin
                    s_nxt.conversions_per_irq_sel    = w[`ARS_F_CONVERSIONS_PER_IRQ_SEL_HI:`ARS_F_CONVERSIONS_PER_IRQ_SEL_LO];
                    s_nxt.scan_en = w[`ARS_B_SCAN_EN];
                    s_nxt.fix_ch  = w[`ARS_F_FCH_HI:`ARS_F_FCH_LO];
                end
                `ARS_OFF_SCAN_LO:   s_nxt.scan_lo   = w[15:0];
                `ARS_OFF_SCAN_HI:   s_nxt.scan_hi   = w[15:0];
                `ARS_OFF_PCFG_OWN:  s_nxt.pcfg_own  = w[`ARS_NPIN-1:0];
                `ARS_OFF_PCFG_PEER: s_nxt.pcfg_peer = w[`ARS_NPIN-1:0];
                `ARS_OFF_IRQ_STAT:  clr = s_axi_wstrb[0] ? s_axi_wdata[`ARS_NIRQ-1:0] : '0;
                `ARS_OFF_IRQ_MASK:  s_nxt.irq_mask  = w[`ARS_NIRQ-1:0];
                default: ;
            endcase
        end

        // Register reads; reading the single DMA-mode buffer marks it fetched
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = ars_reg_word(s_r, s_axi_araddr);
            s_nxt.rresp  = ars_mapped(s_axi_araddr) ? `ARS_RESP_OKAY : `ARS_RESP_SLVERR;
            if (s_axi_araddr == `ARS_OFF_BUF_BASE) begin
                s_nxt.unread = 1'b0;
            end
        end

        // Conversion sequencing
        unique case (s_r.fsm)
            ARS_IDLE: begin
                if (s_r.sample) begin
                    ch = s_r.scan_en ? ars_next_ch({s_r.scan_hi, s_r.scan_lo}, s_r.spos)
                                     : s_r.fix_ch;
                    s_nxt.req.start   = 1'b1;
                    s_nxt.req.channel = ch;
                    s_nxt.cur_ch      = ch;
                    s_nxt.sample      = 1'b0;
                    s_nxt.done        = 1'b0; // R8
                    s_nxt.fsm         = ARS_CONV;
                end
            end
            ARS_CONV: begin
                if (conv_res.done) begin
                    done_set  = 1'b1; // R8
                    // A count left above a lowered field ends the sequence at once
                    wrap      = (s_r.cnt >= s_r.conversions_per_irq_sel); // R12
                    s_nxt.fsm = ARS_IDLE;
                    if (s_r.dma_mode) begin
                        s_nxt.rbuf[0] = conv_res.data; // R6
                        ovr_set       = s_r.unread; // R7
                        s_nxt.unread  = 1'b1;
                    end else begin
                        s_nxt.rbuf[s_r.wptr] = conv_res.data; // R4 R5
                        s_nxt.wptr = ars_step(s_r.wptr, wrap); // R3
                    end
                    s_nxt.cnt  = ars_step(s_r.cnt, wrap); // R1
                    s_nxt.spos = wrap ? '0 : s_r.cur_ch + 5'h01; // R2
                    seq_set    = wrap; // R1
                end
            end
            default: s_nxt.fsm = ARS_IDLE;
        endcase

        // Hardware set wins over software clear
        if (done_set) begin
            s_nxt.done = 1'b1;
        end
        s_nxt.irq_st = (s_r.irq_st & ~clr) | {ovr_set, seq_set};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r     <= '0;
            s_r.fsm <= ARS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_bvalid   = s_r.bvalid;
    assign s_axi_bresp    = s_r.bresp;
    assign s_axi_rvalid   = s_r.rvalid;
    assign s_axi_rdata    = s_r.rdata;
    assign s_axi_rresp    = s_r.rresp;
    assign conv_req       = s_r.req;
    assign pin_digital_en = ars_digital(s_r.pcfg_own, s_r.pcfg_peer); // R10
    assign alt_digital_in = s_r.alt_din;
    assign irq            = |(s_r.irq_st & s_r.irq_mask); // R1

endmodule : ars_seq

`default_nettype wire

// >>> ars_seq_sva.sv
// Port checks for the converter result sequencer
`include "ars_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ars_seq_sva (
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    input wire ars_pkg::ars_conv_req_t conv_req,
    input wire ars_pkg::ars_conv_res_t conv_res,
    input wire logic [`ARS_NPIN-1:0]   pin_digital_en,
    input wire logic [`ARS_NPIN-1:0]   alt_digital_in,
    input wire logic                   irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response missing");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_start_pulse: assert property (conv_req.start |=> !conv_req.start)
        else $error("start longer than one cycle");
    a_chan_hold: assert property ($changed(conv_req.channel) |-> conv_req.start)
        else $error("channel moved without start");
    a_pin_gate: assert property ((alt_digital_in & ~$past(pin_digital_en)) == '0)
        else $error("analog pin reads one");
    a_irq_cause: assert property ($rose(irq) |-> $past(conv_res.done) ||
        $past(s_axi_awvalid && s_axi_awready))
        else $error("irq without event");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_conv: cover property (conv_req.start ##[1:20] conv_res.done);
    c_irq: cover property ($rose(irq));
endmodule : ars_seq_sva
`default_nettype wire

// >>> test_ars_seq.sv
// Register-level tests of the converter result sequencer
`include "ars_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_ars_seq;
    import ars_pkg::*;
    logic clock = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, v;
    logic [15:0] pins = 0;
    logic [3:0] ws = 4'hF;
    logic awr, wr_r, bv, arr, rv, irq;
    logic [1:0] br, rr;
    logic [15:0] den, alt;
    ars_conv_req_t creq;
    ars_conv_res_t cres;
    int num_errors = 0, checked = 0, nc = 0;
    always #4 clock = ~clock;
    ars_seq dut (.clock(clock), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .conv_req(creq), .conv_res(cres), .pin_level(pins),
        .pin_digital_en(den), .alt_digital_in(alt), .irq(irq));
    ars_conv_model conv (.clock(clock), .rst(rst), .conv_req(creq), .conv_res(cres));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        awv <= 1; wv <= 1; awa <= a; wd <= d;
        do @(posedge clock); while (!awr);
        awv <= 0; wv <= 0; bry <= 1;
        do @(posedge clock); while (!bv);
        bry <= 0;
        chk("bresp", {30'h0, er}, {30'h0, br});
    endtask : wr
    task automatic rd(logic [7:0] a, logic [1:0] er);
        arv <= 1; ara <= a;
        do @(posedge clock); while (!arr);
        arv <= 0; rry <= 1;
        do @(posedge clock); while (!rv);
        rry <= 0; v = rdat;
        chk("rresp", {30'h0, er}, {30'h0, rr});
    endtask : rd
    task automatic rc(logic [7:0] a, logic [31:0] e);
        rd(a, 2'h0);
        chk($sformatf("reg %h", a), e, v);
    endtask : rc
    // One manual conversion; done is cleared by the same write that sets sample
    task automatic conv1(logic dma);
        wr(8'h00, {29'h0, dma, 2'b10}, 2'h0);
        do rd(8'h00, 2'h0); while (!v[0]);
        nc++;
    endtask : conv1
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #(8 * 20000);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        rc(8'h00, 0);
        rc(8'h18, 0);
        rd(8'h30, 2'h2);
        chk("unmapped rdata", 0, v);
        wr(8'h30, 32'h1, 2'h2);
        $display("test reset done");
        wr(8'h1C, 32'h3, 2'h0);
        wr(8'h04, 32'h0005000C, 2'h0);
        for (int i = 0; i < 4; i++) begin
            chk("irq early", 0, {31'h0, irq});
            conv1(0);
        end
        chk("irq", 1, {31'h0, irq});
        rc(8'h18, 1);
        rd(8'h20, 2'h0);
        chk("wptr", 0, {28'h0, v[3:0]});
        for (int i = 0; i < 4; i++) rc(8'h40 + 8'(4 * i), {nc - 4 + i, 5'd5});
        wr(8'h1C, 32'h0, 2'h0);
        chk("irq masked", 0, {31'h0, irq});
        wr(8'h18, 32'h1, 2'h0);
        rc(8'h18, 0);
        $display("test sequence done");
        wr(8'h08, 32'h0112, 2'h0);
        wr(8'h04, 32'h0408, 2'h0);
        for (int i = 0; i < 4; i++) conv1(0);
        rc(8'h40, {nc - 1, 5'd1});
        rc(8'h44, {nc - 3, 5'd4});
        rc(8'h48, {nc - 2, 5'd8});
        wr(8'h18, 32'h3, 2'h0);
        $display("test scan done");
        wr(8'h04, 32'h0003_0000, 2'h0);
        conv1(1);
        rc(8'h40, {nc - 1, 5'd3});
        conv1(1);
        conv1(1);
        rc(8'h40, {nc - 1, 5'd3});
        rc(8'h18, 3);
        $display("test dma done");
        pins <= 16'hFFFF;
        wr(8'h10, 32'h00FF, 2'h0);
        wr(8'h14, 32'h0F0F, 2'h0);
        repeat (6) @(posedge clock);
        chk("digital en", 16'h000F, den);
        chk("alt in", 16'h000F, alt);
        ws <= 4'h1;
        wr(8'h10, 32'h0000_FF00, 2'h0);
        ws <= 4'hF;
        rc(8'h10, 32'h0000_0000);
        chk("digital en off", 16'h0000, den);
        $display("test pins done");
        wrap_up();
    end
endmodule : test_ars_seq
bind ars_seq ars_seq_sva u_sva (.clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .conv_req(conv_req), .conv_res(conv_res), .pin_digital_en(pin_digital_en),
    .alt_digital_in(alt_digital_in), .irq(irq));
`default_nettype wire
